/* File: design/fsrem_core.sv */
// Fail-safe escalation: reset error counter, fail-safe output, deep fail.
// Assumes fault and watchdog inputs come from logic on clk_in; the wake
// pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// [RQ1] Every generated reset adds one to the reset error counter.
// [RQ2] Threshold select 0 gives intermediate 3, 1 gives 1; reaching it asserts fail-safe.
// [RQ3] Counter at final value 6 or 2 enters deep fail, regulators off.
// [RQ4] Threshold configuration is written only in the initial safety phase.
// [RQ5] Reset output low longer than eight seconds enters deep fail.
// [RQ6] Listed watchdog, supply, fault, register and request events cause counted resets.
// [RQ7] Listed fault events put the device into the fail-safe state.
// [RQ8] Deep fail ends only by power-on reset or wake pin transition.
// [RQ9] Start-up and low-power-off resume preload counter 1 and assert fail-safe.
// [RQ10] Seven good answers from level 1 bring the counter to 0.
// [RQ11] Fail-safe released only with fault gone, counter 0, correct key.
// [RQ12] Self-test fail, double error, reset short always assert fail-safe.
// [RQ13] Configuration free in initial phase, then Hamming protected.
// [RQ14] Single bit flip corrected transparently and flagged.
// [RQ15] Double bit error flagged, asserts reset and fail-safe, not corrected.
// [RQ16] Release key is the challenge bit-reversed and inverted.
// [RQ17] After six good refreshes the next good answer decrements the counter.
// [RQ18] Watchdog error counter adds two per failure, subtracts one per success.
// [RQ19] Counter never goes below zero; a wrong key keeps fail-safe asserted.
// [RQ20] A key written before all conditions hold is ignored.
module fsrem_core #(
  parameter int unsigned HOLD_LIMIT = fsrem_pkg::DEEP_HOLD_CYC
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        initial_safety_phase_in,
  input  wire logic                        cfg_write_in,
  input  wire logic [fsrem_pkg::CFG_W-1:0] cfg_data_in,
  input  wire logic [fsrem_pkg::CW_LEN-1:0] seu_flip_in,
  input  wire logic                        key_write_in,
  input  wire logic [7:0]                  failsafe_release_key_in,
  input  wire logic [7:0]                  watchdog_challenge_in,
  input  wire logic                        wd_good_in,
  input  wire logic                        wd_bad_in,
  input  wire logic                        wd_timeout_in,
  input  wire logic                        pair_error_in,
  input  wire logic                        undervoltage_in,
  input  wire logic                        overvoltage_in,
  input  wire logic                        core_feedback_deviation_in,
  input  wire logic                        bist_fail_in,
  input  wire logic                        failsafe_short_in,
  input  wire logic                        reset_short_in,
  input  wire logic                        spi_reset_request_in,
  input  wire logic                        external_reset_in,
  input  wire logic                        low_power_off_resume_in,
  input  wire logic                        wake_pin_in,
  input  wire logic                        flag_clear_in,
  output logic                             reset_out_n,
  output logic                             failsafe_out_n,
  output logic                             regulators_on_out,
  output logic                             deep_fail_out,
  output logic                             single_error_flag_out,
  output logic                             double_error_flag_out,
  output logic [fsrem_pkg::CNT_W-1:0]      reset_count_out
);
  localparam int unsigned CW = fsrem_pkg::CW_LEN;
  localparam int unsigned SW = fsrem_pkg::SYN_W;
  localparam int unsigned DW = fsrem_pkg::CFG_W;
  localparam int unsigned NW = fsrem_pkg::CNT_W;

  function automatic logic [SW-1:0] fsrem_syn(input logic [CW-1:0] c);
    logic [SW-1:0] s;
    s = '0;
    for (int i = 1; i < CW; i++) begin
      if (c[i]) begin
        s = s ^ SW'(i);
      end
    end
    return s;
  endfunction

  function automatic logic [CW-1:0] fsrem_enc(input logic [DW-1:0] d);
    logic [CW-1:0] c;
    logic [SW-1:0] s;
    int            k;
    c = '0;
    k = 0;
    for (int i = 1; i < CW; i++) begin
      if ((i & (i - 1)) != 0) begin
        c[i] = d[k];
        k++;
      end
    end
    s = fsrem_syn(c);
    for (int j = 0; j < SW; j++) begin
      c[1 << j] = s[j];
    end
    c[0] = ^c;
    return c;
  endfunction

  function automatic logic [DW-1:0] fsrem_dec(input logic [CW-1:0] c);
    logic [DW-1:0] d;
    int            k;
    d = '0;
    k = 0;
    for (int i = 1; i < CW; i++) begin
      if ((i & (i - 1)) != 0) begin
        d[k] = c[i];
        k++;
      end
    end
    return d;
  endfunction

  logic [CW-1:0] cfg_cw, next_cfg_cw, cw_seen, cw_fixed;
  logic [SW-1:0] syn;
  logic          par, single_now, ded_now;
  logic [DW-1:0] cfg;
  logic [NW-1:0] rst_cnt, next_rst_cnt, inter, final_lvl;
  logic [NW-1:0] wd_err, next_wd_err, refresh, next_refresh;
  logic [7:0]    pulse_cnt, next_pulse_cnt, expected_key;
  logic [31:0]   hold_cnt, next_hold_cnt;
  logic [6:0]    src, src_prev;
  logic          fs_active, next_fs_active, deep, next_deep;
  logic          sec_flag, next_sec_flag, ded_flag, next_ded_flag;
  logic          next_reset_out_n, fault_now, rst_evt, key_ok, good_dec;
  logic          wake_s1, wake_s2, wake_s3, wake_stable, wake_change;

  // Hamming check of the protected configuration.
  always_comb begin
    cw_seen    = cfg_cw ^ seu_flip_in;
    syn        = fsrem_syn(cw_seen);
    par        = ^cw_seen;
    single_now = !initial_safety_phase_in && par; // [RQ14]
    ded_now    = !initial_safety_phase_in && !par && (syn != '0); // [RQ15]
    cw_fixed   = cw_seen;
    if (single_now) begin
      cw_fixed[syn] = ~cw_seen[syn]; // [RQ14]
    end
    cfg = fsrem_dec(cw_fixed);
    expected_key = {<<{~watchdog_challenge_in}}; // [RQ16]
    inter     = cfg[fsrem_pkg::CFG_THR] ? NW'(fsrem_pkg::INTER_SEL1)
                                        : NW'(fsrem_pkg::INTER_SEL0); // [RQ2]
    final_lvl = cfg[fsrem_pkg::CFG_THR] ? NW'(fsrem_pkg::FINAL_SEL1)
                                        : NW'(fsrem_pkg::FINAL_SEL0); // [RQ3]
    wake_change = (wake_s2 == wake_s3) && (wake_s3 != wake_stable);
  end

  // Escalation next state.
  always_comb begin
    src = {ded_now, external_reset_in, failsafe_short_in,
           pair_error_in && cfg[fsrem_pkg::CFG_EN_PAIR],
           undervoltage_in && cfg[fsrem_pkg::CFG_EN_UV],
           overvoltage_in && cfg[fsrem_pkg::CFG_EN_OV],
           core_feedback_deviation_in && cfg[fsrem_pkg::CFG_EN_CORE]};
    fault_now = (|src[3:0]) || bist_fail_in || reset_short_in
                || ded_now || ded_flag; // [RQ7] [RQ12]
    next_wd_err  = wd_err;
    next_refresh = refresh;
    good_dec     = 1'b0;
    key_ok       = key_write_in && failsafe_release_key_in == expected_key;
    rst_evt      = (|(src & ~src_prev)) || spi_reset_request_in
                   || wd_timeout_in
                   || (initial_safety_phase_in && wd_bad_in); // [RQ6]
    if (!initial_safety_phase_in && (wd_bad_in || wd_timeout_in)) begin
      next_wd_err  = wd_err + NW'(fsrem_pkg::WDE_INC); // [RQ18]
      next_refresh = '0;
      if (next_wd_err >= NW'(fsrem_pkg::WDE_LIMIT)) begin
        rst_evt     = 1'b1; // [RQ6]
        next_wd_err = '0;
      end
    end else if (wd_good_in) begin
      next_wd_err = (wd_err != '0) ? wd_err - NW'(1) : wd_err; // [RQ18]
      if (refresh == NW'(fsrem_pkg::REFRESH_LIMIT)) begin
        good_dec     = 1'b1; // [RQ17]
        next_refresh = '0;
      end else begin
        next_refresh = refresh + NW'(1);
      end
    end
    next_rst_cnt   = rst_cnt;
    next_deep      = deep;
    next_pulse_cnt = (pulse_cnt != '0) ? pulse_cnt - 8'h01 : pulse_cnt;
    next_fs_active = fs_active;
    if (deep) begin
      if (wake_change) begin
        next_deep      = 1'b0; // [RQ8]
        next_rst_cnt   = NW'(fsrem_pkg::START_LEVEL);
        next_fs_active = 1'b1;
        next_pulse_cnt = 8'(fsrem_pkg::RST_PULSE_CYC);
      end
    end else if (low_power_off_resume_in) begin
      next_rst_cnt   = NW'(fsrem_pkg::START_LEVEL); // [RQ9]
      next_fs_active = 1'b1;
    end else begin
      if (rst_evt) begin
        next_rst_cnt   = rst_cnt + NW'(1); // [RQ1]
        next_pulse_cnt = 8'(fsrem_pkg::RST_PULSE_CYC);
      end else if (good_dec && rst_cnt != '0) begin
        next_rst_cnt = rst_cnt - NW'(1); // [RQ10] [RQ19]
      end
      if (key_ok && !fault_now && rst_cnt == '0 && !rst_evt) begin
        next_fs_active = 1'b0; // [RQ11] [RQ19] [RQ20]
      end
      if (fault_now || next_rst_cnt >= inter) begin
        next_fs_active = 1'b1; // [RQ2] [RQ7] [RQ12] [RQ15]
      end
    end
    if (!deep && (next_rst_cnt >= final_lvl || hold_cnt >= HOLD_LIMIT)) begin
      next_deep = 1'b1; // [RQ3] [RQ5]
    end
    if (next_deep) begin
      next_fs_active = 1'b1; // [RQ3]
    end
    next_reset_out_n = !(next_deep || next_pulse_cnt != '0
                         || external_reset_in || ded_now); // [RQ3] [RQ15]
    next_hold_cnt = (reset_out_n || deep) ? '0 : hold_cnt + 32'h1; // [RQ5]
    next_sec_flag = single_now || (sec_flag && !flag_clear_in); // [RQ14]
    next_ded_flag = ded_now || (ded_flag && !flag_clear_in); // [RQ15]
    next_cfg_cw   = initial_safety_phase_in ? cfg_cw : cw_fixed; // [RQ14]
    if (initial_safety_phase_in && cfg_write_in) begin
      next_cfg_cw = fsrem_enc(cfg_data_in); // [RQ4] [RQ13]
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_cw            <= fsrem_enc(fsrem_pkg::CFG_RESET);
      rst_cnt           <= NW'(fsrem_pkg::START_LEVEL); // [RQ9]
      wd_err            <= '0;
      refresh           <= '0;
      pulse_cnt         <= 8'(fsrem_pkg::RST_PULSE_CYC);
      hold_cnt          <= '0;
      src_prev          <= '0;
      fs_active         <= 1'b1; // [RQ9]
      deep              <= 1'b0; // [RQ8]
      sec_flag          <= 1'b0;
      ded_flag          <= 1'b0;
      wake_s1           <= 1'b0;
      wake_s2           <= 1'b0;
      wake_s3           <= 1'b0;
      wake_stable       <= 1'b0;
      reset_out_n       <= 1'b0;
      failsafe_out_n    <= 1'b0;
      regulators_on_out <= 1'b1;
    end else begin
      cfg_cw            <= next_cfg_cw;
      rst_cnt           <= next_rst_cnt;
      wd_err            <= next_wd_err;
      refresh           <= next_refresh;
      pulse_cnt         <= next_pulse_cnt;
      hold_cnt          <= next_hold_cnt;
      src_prev          <= src;
      fs_active         <= next_fs_active;
      deep              <= next_deep;
      sec_flag          <= next_sec_flag;
      ded_flag          <= next_ded_flag;
      wake_s1           <= wake_pin_in;
      wake_s2           <= wake_s1;
      wake_s3           <= wake_s2;
      wake_stable       <= (wake_s2 == wake_s3) ? wake_s3 : wake_stable;
      reset_out_n       <= next_reset_out_n;
      failsafe_out_n    <= !next_fs_active;
      regulators_on_out <= !next_deep; // [RQ3]
    end
  end

  assign deep_fail_out         = deep;
  assign single_error_flag_out = sec_flag;
  assign double_error_flag_out = ded_flag;
  assign reset_count_out       = rst_cnt;

  AST_RQ1_INC: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ1]
    rst_evt && !deep && !low_power_off_resume_in |=> rst_cnt == $past(rst_cnt) + NW'(1))
    else $error("Reset did not raise the counter.");
  AST_RQ2_FS: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ2]
    rst_cnt >= inter |-> !failsafe_out_n)
    else $error("Intermediate level without fail-safe.");
  AST_RQ3_DEEP: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ3]
    deep |-> !reset_out_n && !failsafe_out_n && !regulators_on_out)
    else $error("Deep fail outputs wrong.");
  AST_RQ5_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ5]
    hold_cnt >= HOLD_LIMIT |=> deep)
    else $error("Long reset did not enter deep fail.");
  AST_RQ8_STAY: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ8]
    deep && !wake_change |=> deep)
    else $error("Deep fail left without wake.");
  AST_RQ10_DEC: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ10]
    good_dec && !rst_evt && !deep && !low_power_off_resume_in && rst_cnt != '0
    |=> rst_cnt == $past(rst_cnt) - NW'(1))
    else $error("Good answers did not lower the counter.");
  AST_RQ11_REL: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ11]
    $rose(failsafe_out_n) |-> $past(key_ok && !fault_now && rst_cnt == '0))
    else $error("Fail-safe released without all conditions.");
  AST_RQ15_DED: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ15]
    ded_now && !deep |=> ded_flag && !failsafe_out_n ##[0:2] !reset_out_n)
    else $error("Double error not acted upon.");
  AST_RQ18_ERR: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ18]
    !initial_safety_phase_in && wd_bad_in && wd_err < NW'(4)
    |=> wd_err == $past(wd_err) + NW'(2))
    else $error("Watchdog error counter not raised by two.");
  AST_RQ14_SEC: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RQ14]
    single_now |=> sec_flag && fsrem_dec(cfg_cw) == $past(cfg))
    else $error("Single error not corrected.");
  COV_DEEP: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(deep));
  COV_REL: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(failsafe_out_n));
  COV_SEC: cover property (@(posedge clk_in) disable iff (!rst_n_in) single_now);
endmodule
`default_nettype wire

/* File: pkg/fsrem_pkg.sv */
// Constants of the fail-safe reset error manager.
// Assumes a 200 MHz core clock; RST_PULSE_CYC and DEEP_HOLD_CYC derive from it here.
package fsrem_pkg;
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned CNT_W          = 3;
  localparam int unsigned START_LEVEL    = 1;
  localparam int unsigned INTER_SEL0     = 3;
  localparam int unsigned FINAL_SEL0     = 6;
  localparam int unsigned INTER_SEL1     = 1;
  localparam int unsigned FINAL_SEL1     = 2;
  localparam int unsigned WDE_LIMIT      = 6;
  localparam int unsigned WDE_INC        = 2;
  localparam int unsigned REFRESH_LIMIT  = 6;
  localparam int unsigned RST_PULSE_NS   = 100;
  localparam int unsigned RST_PULSE_CYC  =
    (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DEEP_HOLD_S    = 8;
  localparam int unsigned DEEP_HOLD_CYC  = DEEP_HOLD_S * CLK_MHZ * 1000000;
  // Configuration word layout.
  localparam int unsigned CFG_W          = 5;
  localparam int unsigned CFG_THR        = 0;
  localparam int unsigned CFG_EN_PAIR    = 1;
  localparam int unsigned CFG_EN_UV      = 2;
  localparam int unsigned CFG_EN_OV      = 3;
  localparam int unsigned CFG_EN_CORE    = 4;
  localparam logic [4:0]  CFG_RESET      = 5'h1E;
  // Code word: bit 0 overall parity, positions 1..9 Hamming layout.
  localparam int unsigned CW_LEN         = 10;
  localparam int unsigned SYN_W          = 4;
endpackage

/* File: verif/fsrem_mcu_model.sv */
// Controller model: watchdog answers, release key and config writes.
// Assumes the bench calls its tasks and clk_in is the device clock.
`timescale 1ns/1ps
`default_nettype none
module fsrem_mcu_model (
  input  wire logic       clk_in,
  input  wire logic       phase_in,
  input  wire logic [7:0] challenge_in,
  output logic            wd_good_out,
  output logic            wd_bad_out,
  output logic            key_write_out,
  output logic [7:0]      key_out,
  output logic            cfg_write_out,
  output logic [4:0]      cfg_data_out
);
  initial begin
    {wd_good_out, wd_bad_out, key_write_out, cfg_write_out} = 4'h0;
    key_out = 8'h00;
    cfg_data_out = 5'h00;
  end
  task automatic answer(input logic ok);
    @(negedge clk_in);
    wd_good_out = ok;
    wd_bad_out = !ok;
    @(negedge clk_in);
    {wd_good_out, wd_bad_out} = 2'h0;
  endtask
  task automatic send_key(input logic right);
    int i;
    @(negedge clk_in);
    for (i = 0; i < 8; i++) begin
      key_out[i] = !challenge_in[7-i];
    end
    if (!right) begin
      key_out[0] = !key_out[0];
    end
    key_write_out = 1'b1;
    @(negedge clk_in);
    key_write_out = 1'b0;
    key_out = ~key_out;
  endtask
  task automatic write_cfg(input logic [4:0] data, input logic late);
    @(negedge clk_in);
    if (phase_in || late) begin
      cfg_data_out = data;
      cfg_write_out = 1'b1;
      @(negedge clk_in);
      cfg_write_out = 1'b0;
      cfg_data_out = ~cfg_data_out;
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/test_failsafe_reset_error_manager.sv */
// Self-checking bench of the fail-safe reset error manager.
// Assumes fsrem_core with a short hold limit and the controller model.
`timescale 1ns/1ps
`default_nettype none
module test_failsafe_reset_error_manager;
  typedef struct {int kind; logic [2:0] val;} fsrem_note_t;
  localparam int CNT = 0, FS = 1, DP = 2, RG = 3, RS = 4, SF = 5, DF = 6;
  logic       clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       phase = 1'b1;
  logic [9:0] flip = 10'h000;
  logic [7:0] chal = 8'h00;
  logic [5:0] lvl = 6'h00;
  logic       tmo = 1'b0, spi = 1'b0, lpo = 1'b0, wake = 1'b0, bist = 1'b0;
  logic       rsh = 1'b0, fclr = 1'b0;
  logic       wg, wb, kw, cw, rst_o, fs_n, reg_on, deep, sf, df;
  logic [7:0] key;
  logic [4:0] cd;
  logic [2:0] cnt;
  logic [5:0] obits;
  int         miscompares = 0, tests_run = 0, seed;
  fsrem_note_t notes[$];
  event       look;
  string      bname[6] = '{"failsafe_out_n", "deep_fail_out",
    "regulators_on_out", "reset_out_n", "single_error_flag_out",
    "double_error_flag_out"};
  assign obits = {df, sf, rst_o, reg_on, deep, fs_n};
  always #2.5 clk_in = !clk_in;
  fsrem_mcu_model mcu_u (.clk_in(clk_in), .phase_in(phase),
    .challenge_in(chal), .wd_good_out(wg), .wd_bad_out(wb),
    .key_write_out(kw), .key_out(key), .cfg_write_out(cw),
    .cfg_data_out(cd));
  fsrem_core #(.HOLD_LIMIT(200)) dut_u (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .initial_safety_phase_in(phase),
    .cfg_write_in(cw), .cfg_data_in(cd), .seu_flip_in(flip),
    .key_write_in(kw), .failsafe_release_key_in(key),
    .watchdog_challenge_in(chal), .wd_good_in(wg), .wd_bad_in(wb),
    .wd_timeout_in(tmo), .pair_error_in(lvl[0]), .undervoltage_in(lvl[1]),
    .overvoltage_in(lvl[2]), .core_feedback_deviation_in(lvl[3]),
    .bist_fail_in(bist), .failsafe_short_in(lvl[4]),
    .reset_short_in(rsh), .spi_reset_request_in(spi),
    .external_reset_in(lvl[5]), .low_power_off_resume_in(lpo),
    .wake_pin_in(wake), .flag_clear_in(fclr), .reset_out_n(rst_o),
    .failsafe_out_n(fs_n), .regulators_on_out(reg_on),
    .deep_fail_out(deep), .single_error_flag_out(sf),
    .double_error_flag_out(df), .reset_count_out(cnt));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic note(input int kind, input logic [2:0] val);
    notes.push_back('{kind, val});
    -> look;
  endtask
  task automatic expect3(input logic [2:0] c, input logic f, input logic d);
    note(CNT, c);
    note(FS, {2'h0, f});
    note(DP, {2'h0, d});
  endtask
  task automatic cmp_cnt(input logic [2:0] exp);
    tests_run++;
    if (cnt !== exp) begin
      miscompares++;
      $display("wrong value reset_count_out exp %0h got %0h", exp, cnt);
    end
  endtask
  task automatic cmp_bit(input int idx, input logic exp);
    tests_run++;
    if (obits[idx] !== exp) begin
      miscompares++;
      $display("wrong value %s exp %b got %b", bname[idx], exp, obits[idx]);
    end
  endtask
  task automatic hit(input int src);
    lvl = 6'(1 << src);
    spi = (src == 6);
    tmo = (src == 7);
    lpo = (src == 8);
    cyc(1);
    lvl = 6'h00;
    spi = 1'b0;
    tmo = 1'b0;
    lpo = 1'b0;
    cyc(25);
  endtask
  initial begin
    fsrem_note_t n;
    forever begin
      @(look);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        if (n.kind == CNT) cmp_cnt(n.val);
        else cmp_bit(n.kind - 1, n.val[0]);
      end
    end
  end
  initial begin
    int i;
    seed = 91912;
    cyc(5);
    expect3(3'h1, 1'b0, 1'b0);
    rst_n_in = 1'b1;
    for (i = 0; i < 100 && rst_o !== 1'b1; i++)
      cyc(1);
    if (i == 100) begin
      miscompares++;
      stop_test();
    end
    chal = 8'($random(seed));
    mcu_u.send_key(1'b1);
    cyc(2);
    note(FS, 3'h0);
    mcu_u.write_cfg(5'h1E, 1'b0);
    phase = 1'b0;
    mcu_u.write_cfg(5'h1F, 1'b1);
    $display("test start and config done");
    repeat (6) mcu_u.answer(1'b1);
    cyc(2);
    note(CNT, 3'h1);
    mcu_u.answer(1'b1);
    cyc(2);
    note(CNT, 3'h0);
    repeat (7) mcu_u.answer(1'b1);
    cyc(2);
    note(CNT, 3'h0);
    chal = 8'($random(seed));
    mcu_u.send_key(1'b0);
    cyc(2);
    note(FS, 3'h0);
    bist = !bist;
    mcu_u.send_key(1'b1);
    cyc(2);
    note(FS, 3'h0);
    bist = !bist;
    cyc(2);
    mcu_u.send_key(1'b1);
    cyc(2);
    note(FS, 3'h1);
    rsh = !rsh;
    cyc(2);
    note(FS, 3'h0);
    rsh = !rsh;
    cyc(2);
    mcu_u.send_key(1'b1);
    cyc(2);
    note(FS, 3'h1);
    $display("test release key done");
    hit(6);
    expect3(3'h1, 1'b1, 1'b0);
    mcu_u.answer(1'b0);
    mcu_u.answer(1'b0);
    cyc(2);
    note(CNT, 3'h1);
    mcu_u.answer(1'b0);
    cyc(25);
    note(CNT, 3'h2);
    hit(7);
    expect3(3'h3, 1'b0, 1'b0);
    hit(1);
    hit(2);
    hit(0);
    expect3(3'h6, 1'b0, 1'b1);
    note(RG, 3'h0);
    note(RS, 3'h0);
    hit(6);
    note(CNT, 3'h6);
    wake = !wake;
    cyc(30);
    expect3(3'h1, 1'b0, 1'b0);
    note(RG, 3'h1);
    $display("test escalation done");
    hit(3);
    hit(4);
    note(CNT, 3'h3);
    lvl[5] = 1'b1;
    cyc(230);
    note(DP, 3'h1);
    note(CNT, 3'h4);
    lvl[5] = 1'b0;
    wake = !wake;
    cyc(30);
    expect3(3'h1, 1'b0, 1'b0);
    $display("test long reset done");
    flip = 10'h008;
    cyc(1);
    flip = 10'h000;
    cyc(3);
    note(SF, 3'h1);
    note(CNT, 3'h1);
    flip = 10'h006;
    cyc(1);
    flip = 10'h000;
    cyc(2);
    note(DF, 3'h1);
    note(RS, 3'h0);
    cyc(25);
    note(CNT, 3'h2);
    hit(8);
    note(CNT, 3'h1);
    fclr = !fclr;
    cyc(1);
    fclr = !fclr;
    cyc(2);
    note(SF, 3'h0);
    note(DF, 3'h1);
    $display("test code protection done");
    cyc(1);
    stop_test();
  end
endmodule
`default_nettype wire
